/* hw/gpmc_pkg.sv */
// constants for the global performance-monitor control block
package gpmc_pkg;
  localparam int unsigned GPMC_ADDR_W = 12;
  localparam logic [11:0] GPMC_OFS_CONTROL = 12'hc00;
  localparam logic [11:0] GPMC_OFS_STATUS = 12'hc01;
  localparam logic [11:0] GPMC_OFS_CONFIG = 12'hc06;
  localparam int unsigned GPMC_FREEZE_BIT = 31;
  localparam int unsigned GPMC_WAKE_BIT = 30;
  localparam int unsigned GPMC_UNFREEZE_BIT = 29;
  localparam int unsigned GPMC_MASK_W = 15;
  localparam int unsigned GPMC_STATUS_W = 27;
  localparam int unsigned GPMC_OVF_CYCLE_BIT = 0;
  localparam int unsigned GPMC_OVF_GLOBAL_BIT = 1;
  localparam int unsigned GPMC_OVF_POWER_BIT = 2;
  localparam int unsigned GPMC_OVF_CACHE_LSB = 3;
  localparam int unsigned GPMC_OVF_HOME0_BIT = 18;
  localparam int unsigned GPMC_OVF_HOME1_BIT = 19;
  localparam int unsigned GPMC_OVF_MEM0_BIT = 20;
  localparam int unsigned GPMC_OVF_MEM1_BIT = 21;
  localparam int unsigned GPMC_OVF_LINK0_BIT = 22;
  localparam int unsigned GPMC_OVF_LINK1_BIT = 23;
  localparam int unsigned GPMC_OVF_RING0_BIT = 24;
  localparam int unsigned GPMC_OVF_RING1_BIT = 25;
  localparam int unsigned GPMC_OVF_PCIE_BIT = 26;
  localparam int unsigned GPMC_NUMC_W = 4;
  localparam logic [3:0] GPMC_NUMC_RESET = 4'h8;
  localparam logic [14:0] GPMC_MASK_RESET = 15'h0000;
  localparam logic [26:0] GPMC_STATUS_RESET = 27'h0000000;
  typedef enum logic [1:0] {
    GPMC_DLV_IDLE = 2'b00,
    GPMC_DLV_WAKE = 2'b01,
    GPMC_DLV_SEND = 2'b10
  } gpmc_dlv_type;
endpackage : gpmc_pkg

/* hw/gpmc_sticky.sv */
// sticky write-one-to-clear flag bank, set wins over clear
`timescale 1ns/1ps
module gpmc_sticky #(
  parameter int unsigned WIDTH = 27
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  output logic [WIDTH-1:0] flags_o
);
  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } gpmc_sticky_state_type;
  gpmc_sticky_state_type st_q;
  gpmc_sticky_state_type st_d;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("gpmc_sticky: WIDTH must be at least 1");
    end
  end

  always_comb
  begin
    st_d = st_q;
    st_d.flags = (st_q.flags & ~clr_i) | set_i;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      st_q.flags <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign flags_o = st_q.flags;

  AST_SET_HOLDS: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (set_i != '0) |=> ((flags_o & $past(set_i)) == $past(set_i)))
    else $error("a reported overflow was lost");
  AST_ZERO_WRITE_KEEPS: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (clr_i == '0) |=> ((flags_o & $past(flags_o)) == $past(flags_o)))
    else $error("flag dropped without a clear");
endmodule : gpmc_sticky

/* hw/gpmc_top.sv */
// global performance-monitor control, status and interrupt steering
// Functional notes
// - control bit 31 write freezes all counters
// - control bit 29 write unfreezes all counters; bit 31 or an overflow in the same cycle wins
// - bit 30 selects waking sleeping cores first
// - bits 14:0 select interrupted cores; zero none
// - wake sleeping selected cores before interrupting
// - status accumulates and holds each overflow flag
// - writing one clears flag; zero keeps it
// - bits 26:18 ring, link, memory, home flags
// - bits 17:3 one flag per cache box
// - bit 2 flags power unit overflow
// - bit 1 flags global unit counter overflow
// - bit 0 flags global cycle counter overflow
// - config bits 3:0 count cache sets, reset 8
// - global flags first, then box status
// - simultaneous overflows are all recorded
// - box status bits clear by writing one
// - any overflow message asserts global freeze
// - an overflow message while delivery is idle interrupts selected cores; sleeping ones only when bit 30 is set
`timescale 1ns/1ps
module gpmc_top
  import gpmc_pkg::*;
#(
  parameter int unsigned NUM_CACHE = 15
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // register access port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [gpmc_pkg::GPMC_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  // one-cycle overflow messages from the boxes
  input wire logic overflow_cycle_counter_i,
  input wire logic overflow_global_unit_i,
  input wire logic overflow_power_unit_i,
  input wire logic [NUM_CACHE-1:0] overflow_cache_boxes_i,
  input wire logic overflow_home_agent_0_i,
  input wire logic overflow_home_agent_1_i,
  input wire logic overflow_memctl_0_i,
  input wire logic overflow_memctl_1_i,
  input wire logic overflow_link_port_0_i,
  input wire logic overflow_link_port_1_i,
  input wire logic overflow_link_ring_stop_0_i,
  input wire logic overflow_link_ring_stop_1_i,
  input wire logic overflow_pcie_ring_stop_i,
  // core state and delivery
  input wire logic [gpmc_pkg::GPMC_MASK_W-1:0] core_awake_i,
  output logic [gpmc_pkg::GPMC_MASK_W-1:0] core_wake_o,
  output logic [gpmc_pkg::GPMC_MASK_W-1:0] core_interrupt_o,
  // box freeze control
  output logic freeze_all_o,
  output logic box_box_clear_unused_o
);
  import gpmc_pkg::*;

  initial
  begin
    if (NUM_CACHE < 1 || NUM_CACHE > 15)
    begin
      $error("gpmc_top: NUM_CACHE must be 1 to 15");
    end
    if (GPMC_OVF_CACHE_LSB + 15 != GPMC_OVF_HOME0_BIT)
    begin
      $error("gpmc_top: cache flags must end below the home agent flags");
    end
    if (GPMC_OVF_PCIE_BIT + 1 != GPMC_STATUS_W)
    begin
      $error("gpmc_top: pcie ring flag must be the top status bit");
    end
    if (GPMC_MASK_W != 15)
    begin
      $error("gpmc_top: core mask must be 15 bits");
    end
  end

  typedef struct packed {
    logic freeze;
    logic wake_before_interrupt;
    logic [GPMC_MASK_W-1:0] core_select;
    logic [GPMC_NUMC_W-1:0] num_cache_sets;
    logic [31:0] rdata;
    gpmc_dlv_type dlv;
    logic [GPMC_MASK_W-1:0] targets;
    logic [GPMC_MASK_W-1:0] wake;
    logic [GPMC_MASK_W-1:0] intr;
  } gpmc_state_type;

  gpmc_state_type st_q;
  gpmc_state_type st_d;

  logic [GPMC_STATUS_W-1:0] ovf_set;
  logic [GPMC_STATUS_W-1:0] ovf_clr;
  logic [GPMC_STATUS_W-1:0] ovf_flags;
  logic [14:0] cache_ext;
  logic any_overflow;
  logic wr_ctl;
  logic wr_cfg;
  logic wr_sts;
  logic [GPMC_MASK_W-1:0] pending_wake;

  ////////////////////////////////////////////////////////////////////////////
  // overflow collection

  assign cache_ext = 15'(overflow_cache_boxes_i);

  always_comb
  begin
    ovf_set = '0;
    ovf_set[GPMC_OVF_CYCLE_BIT] = overflow_cycle_counter_i;
    ovf_set[GPMC_OVF_GLOBAL_BIT] = overflow_global_unit_i;
    ovf_set[GPMC_OVF_POWER_BIT] = overflow_power_unit_i;
    ovf_set[GPMC_OVF_CACHE_LSB +: 15] = cache_ext;
    ovf_set[GPMC_OVF_HOME0_BIT] = overflow_home_agent_0_i;
    ovf_set[GPMC_OVF_HOME1_BIT] = overflow_home_agent_1_i;
    ovf_set[GPMC_OVF_MEM0_BIT] = overflow_memctl_0_i;
    ovf_set[GPMC_OVF_MEM1_BIT] = overflow_memctl_1_i;
    ovf_set[GPMC_OVF_LINK0_BIT] = overflow_link_port_0_i;
    ovf_set[GPMC_OVF_LINK1_BIT] = overflow_link_port_1_i;
    ovf_set[GPMC_OVF_RING0_BIT] = overflow_link_ring_stop_0_i;
    ovf_set[GPMC_OVF_RING1_BIT] = overflow_link_ring_stop_1_i;
    ovf_set[GPMC_OVF_PCIE_BIT] = overflow_pcie_ring_stop_i;
  end

  assign any_overflow = |ovf_set;
  assign wr_ctl = reg_wr_i && (reg_addr_i == GPMC_OFS_CONTROL);
  assign wr_sts = reg_wr_i && (reg_addr_i == GPMC_OFS_STATUS);
  assign wr_cfg = reg_wr_i && (reg_addr_i == GPMC_OFS_CONFIG);
  assign ovf_clr = wr_sts ? reg_wdata_i[GPMC_STATUS_W-1:0] : '0;

  // global summary flags; box-level flags live in each box
  gpmc_sticky #(
    .WIDTH(GPMC_STATUS_W)
  ) u_status (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .set_i(ovf_set),
    .clr_i(ovf_clr),
    .flags_o(ovf_flags)
  );

  assign pending_wake = st_q.targets & ~core_awake_i;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_d = st_q;
    st_d.wake = '0;
    st_d.intr = '0;
    if (wr_ctl)
    begin
      st_d.wake_before_interrupt = reg_wdata_i[GPMC_WAKE_BIT];
      st_d.core_select = reg_wdata_i[GPMC_MASK_W-1:0];
      if (reg_wdata_i[GPMC_UNFREEZE_BIT])
      begin
        st_d.freeze = 1'b0;
      end
      if (reg_wdata_i[GPMC_FREEZE_BIT])
      begin
        st_d.freeze = 1'b1;
      end
    end
    if (wr_cfg)
    begin
      st_d.num_cache_sets = reg_wdata_i[GPMC_NUMC_W-1:0];
    end
    if (any_overflow)
    begin
      st_d.freeze = 1'b1;
    end
    unique case (st_q.dlv)
      GPMC_DLV_IDLE:
      begin
        if (any_overflow && (st_q.core_select != '0))
        begin
          st_d.targets = st_q.core_select;
          st_d.dlv = st_q.wake_before_interrupt ? GPMC_DLV_WAKE : GPMC_DLV_SEND;
        end
      end
      GPMC_DLV_WAKE:
      begin
        st_d.wake = pending_wake;
        if (pending_wake == '0)
        begin
          st_d.dlv = GPMC_DLV_SEND;
        end
      end
      GPMC_DLV_SEND:
      begin
        // awake-only delivery when the wake option is clear
        st_d.intr = st_q.targets & core_awake_i;
        st_d.dlv = GPMC_DLV_IDLE;
      end
      default:
      begin
        st_d.dlv = GPMC_DLV_IDLE;
      end
    endcase
    st_d.rdata = '0;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        GPMC_OFS_CONTROL:
        begin
          // freeze and unfreeze bits read zero
          st_d.rdata[GPMC_WAKE_BIT] = st_q.wake_before_interrupt;
          st_d.rdata[GPMC_MASK_W-1:0] = st_q.core_select;
        end
        GPMC_OFS_STATUS:
        begin
          st_d.rdata[GPMC_STATUS_W-1:0] = ovf_flags;
        end
        GPMC_OFS_CONFIG:
        begin
          st_d.rdata[GPMC_NUMC_W-1:0] = st_q.num_cache_sets;
        end
        default:
        begin
          st_d.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      st_q.freeze <= 1'b0;
      st_q.wake_before_interrupt <= 1'b0;
      st_q.core_select <= GPMC_MASK_RESET;
      st_q.num_cache_sets <= GPMC_NUMC_RESET;
      st_q.rdata <= '0;
      st_q.dlv <= GPMC_DLV_IDLE;
      st_q.targets <= '0;
      st_q.wake <= '0;
      st_q.intr <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o = st_q.rdata;
  assign freeze_all_o = st_q.freeze;
  assign core_wake_o = st_q.wake;
  assign core_interrupt_o = st_q.intr;
  assign box_box_clear_unused_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_FREEZE_WIN: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (wr_ctl && reg_wdata_i[GPMC_FREEZE_BIT]) |=> freeze_all_o)
    else $error("freeze lost against unfreeze");
  AST_UNFREEZE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (wr_ctl && reg_wdata_i[GPMC_UNFREEZE_BIT] && !reg_wdata_i[GPMC_FREEZE_BIT]
     && !any_overflow) |=> !freeze_all_o)
    else $error("unfreeze did not resume counting");
  AST_OVF_FREEZE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    any_overflow |=> freeze_all_o)
    else $error("overflow did not freeze");
  AST_STICKY_CACHE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    overflow_cache_boxes_i[0] |=> ovf_flags[GPMC_OVF_CACHE_LSB])
    else $error("cache flag not set");
  AST_PCIE_FLAG: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    overflow_pcie_ring_stop_i |=> ovf_flags[GPMC_OVF_PCIE_BIT])
    else $error("pcie ring flag not set");
  AST_CYCLE_FLAG: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    overflow_cycle_counter_i |=> ovf_flags[GPMC_OVF_CYCLE_BIT])
    else $error("cycle flag not set");
  AST_CLEAR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (wr_sts && reg_wdata_i[GPMC_OVF_POWER_BIT] && !overflow_power_unit_i)
    |=> !ovf_flags[GPMC_OVF_POWER_BIT])
    else $error("write one did not clear");
  AST_NO_MASK: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (st_q.dlv == GPMC_DLV_IDLE && st_q.core_select == '0) |=> core_interrupt_o == '0)
    else $error("interrupt with empty mask");
  AST_INTR_IN_MASK: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (core_interrupt_o & ~$past(st_q.targets)) == '0)
    else $error("interrupt outside selected cores");
  AST_WAKE_FIRST: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (st_q.dlv == GPMC_DLV_WAKE) |=> (core_interrupt_o == '0))
    else $error("interrupt before wake done");
  AST_CFG_RESET: assert property (@(posedge core_clk_i)
    !nrst_i |=> st_q.num_cache_sets == GPMC_NUMC_RESET)
    else $error("config count reset wrong");
  AST_RD_WO_ZERO: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (reg_rd_i && reg_addr_i == GPMC_OFS_CONTROL) |=> reg_rdata_o[31] == 1'b0
    && reg_rdata_o[29] == 1'b0)
    else $error("write-only bit read nonzero");

  // flags, delivery and register contents
  AST_POWER_FLAG: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    overflow_power_unit_i |=> ovf_flags[GPMC_OVF_POWER_BIT])
    else $error("power unit flag not set");
  AST_GLOBAL_FLAG: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    overflow_global_unit_i |=> ovf_flags[GPMC_OVF_GLOBAL_BIT])
    else $error("global unit flag not set");
  AST_HOME_FLAG: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    overflow_home_agent_0_i |=> ovf_flags[GPMC_OVF_HOME0_BIT])
    else $error("home agent flag not set");
  AST_CACHE_TOP: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    overflow_cache_boxes_i[NUM_CACHE-1] |=> ovf_flags[GPMC_OVF_CACHE_LSB+NUM_CACHE-1])
    else $error("last cache flag not set");
  AST_CACHE_CLEAR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (wr_sts && reg_wdata_i[GPMC_OVF_CACHE_LSB] && !overflow_cache_boxes_i[0])
    |=> !ovf_flags[GPMC_OVF_CACHE_LSB])
    else $error("cache flag not cleared by write one");
  AST_SEND_AWAKE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (st_q.dlv == GPMC_DLV_SEND) |=> ((core_interrupt_o & ~$past(core_awake_i)) == '0))
    else $error("interrupt sent to a sleeping core");
  AST_WAKE_ASLEEP: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (st_q.dlv == GPMC_DLV_WAKE)
    |=> (core_wake_o == ($past(st_q.targets) & ~$past(core_awake_i))))
    else $error("wake not sent to every sleeping target");
  AST_WAKE_ONLY: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (st_q.dlv != GPMC_DLV_WAKE) |=> (core_wake_o == '0))
    else $error("wake outside the wake phase");
  AST_DELIVER: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (st_q.dlv == GPMC_DLV_IDLE && any_overflow && st_q.core_select != '0
     && !st_q.wake_before_interrupt)
    |=> ##1 (core_interrupt_o == ($past(st_q.core_select, 2) & $past(core_awake_i))))
    else $error("overflow interrupt not delivered");
  AST_MASK_LOAD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    wr_ctl |=> (st_q.core_select == $past(reg_wdata_i[GPMC_MASK_W-1:0])))
    else $error("core mask not loaded");
  AST_CONTROL_READ: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (reg_rd_i && reg_addr_i == GPMC_OFS_CONTROL)
    |=> (reg_rdata_o[GPMC_WAKE_BIT] == $past(st_q.wake_before_interrupt)))
    else $error("wake option read wrong");
  AST_CFG_WRITE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    wr_cfg |=> (st_q.num_cache_sets == $past(reg_wdata_i[GPMC_NUMC_W-1:0])))
    else $error("config count not written");
  AST_CFG_READ: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (reg_rd_i && reg_addr_i == GPMC_OFS_CONFIG)
    |=> (reg_rdata_o == 32'($past(st_q.num_cache_sets))))
    else $error("config count read wrong");
  AST_STATUS_READ: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (reg_rd_i && reg_addr_i == GPMC_OFS_STATUS) |=> (reg_rdata_o == 32'($past(ovf_flags))))
    else $error("status flags read wrong");
endmodule : gpmc_top

/* tb/gpmc_core_model.sv */
// model of the cores that receive the performance interrupt
`timescale 1ns/1ps
module gpmc_core_model #(
  parameter int unsigned WAKE_DLY = 3
) (
  input wire logic core_clk_i,
  input wire logic [14:0] sleep_i,
  input wire logic [14:0] core_wake_i,
  output logic [14:0] core_awake_o
);
  logic [14:0] asleep_q = '0;
  logic [14:0] pend_q = '0;
  int cnt_q = 0;
  // a woken core needs a few cycles before it reports awake
  always @(posedge core_clk_i)
  begin
    if (sleep_i != '0)
      asleep_q <= sleep_i;
    pend_q <= pend_q | (core_wake_i & asleep_q);
    cnt_q <= (pend_q != '0) ? cnt_q + 1 : 0;
    if (cnt_q == WAKE_DLY)
    begin
      asleep_q <= asleep_q & ~pend_q;
      pend_q <= '0;
    end
  end
  assign core_awake_o = ~asleep_q;
endmodule : gpmc_core_model

/* tb/gpmc_top_bench.sv */
// self-checking bench for the global performance-monitor control block
`timescale 1ns/1ps
module gpmc_top_bench;
  import gpmc_pkg::*;
  logic clk = '0, nrst = '0, wr = '0, rd = '0, frz, rd_taken = '0, w;
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [26:0] ovf = '0;
  logic [14:0] awake, wake, intr, m, s, sleep = '0, woke = '0;
  logic [15:0] lf = 16'h7749;
  logic [31:0] rq[$];
  logic [14:0] iq[$];
  int n_fail = 0, checks = 0, cyc = 0, i;
  gpmc_top #(.NUM_CACHE(15)) gpmc_top_inst (.core_clk_i(clk), .nrst_i(nrst), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .overflow_cycle_counter_i(ovf[0]), .overflow_global_unit_i(ovf[1]),
    .overflow_power_unit_i(ovf[2]), .overflow_cache_boxes_i(ovf[17:3]),
    .overflow_home_agent_0_i(ovf[18]), .overflow_home_agent_1_i(ovf[19]),
    .overflow_memctl_0_i(ovf[20]), .overflow_memctl_1_i(ovf[21]),
    .overflow_link_port_0_i(ovf[22]), .overflow_link_port_1_i(ovf[23]),
    .overflow_link_ring_stop_0_i(ovf[24]), .overflow_link_ring_stop_1_i(ovf[25]),
    .overflow_pcie_ring_stop_i(ovf[26]), .core_awake_i(awake), .core_wake_o(wake),
    .core_interrupt_o(intr), .freeze_all_o(frz), .box_box_clear_unused_o());
  gpmc_core_model gpmc_core_model_inst (.core_clk_i(clk), .sleep_i(sleep),
    .core_wake_i(wake), .core_awake_o(awake));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  task automatic end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : wreg
  task automatic rreg(input logic [11:0] a, input logic [31:0] e);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    rq.push_back(e);
    @(negedge clk);
    rd = 1'b0;
  endtask : rreg
  task automatic pulse(input logic [26:0] v);
    @(negedge clk);
    ovf = v;
    @(negedge clk);
    ovf = '0;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) rd_taken <= rd;
  // read data and interrupts are looked at while they stand
  always @(negedge clk)
  begin
    cyc++;
    if (rd_taken)
      chk(rdata, rq.pop_front());
    if (intr !== '0)
      chk({17'h0, intr}, (iq.size() != 0) ? {17'h0, iq.pop_front()} : 32'hffffffff);
    if (wake !== '0)
    begin
      chk({17'h0, wake & ~(m & s)}, 32'h0);
      woke = woke | wake;
    end
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    rreg(GPMC_OFS_CONTROL, 32'h0);
    rreg(GPMC_OFS_STATUS, 32'h0);
    rreg(GPMC_OFS_CONFIG, 32'h8);
    rreg(12'h123, 32'h0);
    wreg(GPMC_OFS_CONFIG, 32'h3);
    rreg(GPMC_OFS_CONFIG, 32'h3);
    // every source alone with an empty core mask, so no interrupt may appear
    for (int b = 0; b < 27; b++)
    begin
      pulse(27'h1 << b);
      chk({31'h0, frz}, 32'h1);
      rreg(GPMC_OFS_STATUS, 32'h1 << b);
      wreg(GPMC_OFS_STATUS, 32'h0);
      rreg(GPMC_OFS_STATUS, 32'h1 << b);
      wreg(GPMC_OFS_STATUS, 32'h1 << b);
      rreg(GPMC_OFS_STATUS, 32'h0);
    end
    wreg(GPMC_OFS_CONTROL, 32'h20000000);
    chk({31'h0, frz}, 32'h0);
    wreg(GPMC_OFS_CONTROL, 32'h80000000);
    chk({31'h0, frz}, 32'h1);
    wreg(GPMC_OFS_CONTROL, 32'h20000000);
    wreg(GPMC_OFS_CONTROL, 32'ha0000000);
    chk({31'h0, frz}, 32'h1);
    rreg(GPMC_OFS_CONTROL, 32'h0);
    pulse(27'h7ffffff);
    rreg(GPMC_OFS_STATUS, 32'h07ffffff);
    wreg(GPMC_OFS_STATUS, 32'h07ffffff);
    // random masks and sleeping cores, with and without waking first
    for (int k = 0; k < 6; k++)
    begin
      lf = nxt(lf);
      s = (lf[14:0] | 15'h0001) & ~15'h0002;
      lf = nxt(lf);
      m = lf[14:0] | 15'h0002;
      w = k[0];
      @(negedge clk);
      sleep = s;
      @(negedge clk);
      sleep = '0;
      wreg(GPMC_OFS_CONTROL, {1'b0, w, 1'b1, 2'b00, 12'h0, m});
      rreg(GPMC_OFS_CONTROL, {1'b0, w, 15'h0, m});
      iq.push_back(w ? m : (m & ~s));
      woke = '0;
      pulse(27'h1 << (k + 3));
      for (i = 0; i < 60 && iq.size() != 0; i++)
        @(negedge clk);
      chk(32'(iq.size()), 32'h0);
      chk({17'h0, woke}, {17'h0, (w ? (m & s) : 15'h0)});
      wreg(GPMC_OFS_STATUS, 32'h1 << (k + 3));
    end
    repeat (10) @(negedge clk);
    // reset again in mid-run: registers return to their reset values
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    rreg(GPMC_OFS_CONFIG, 32'h8);
    rreg(GPMC_OFS_CONTROL, 32'h0);
    rreg(GPMC_OFS_STATUS, 32'h0);
    repeat (10) @(negedge clk);
    end_sim();
  end
endmodule : gpmc_top_bench
